// >>> rtl/dlra_link_regs.sv
/*
 * Device end of the two-wire debug link: frame engine, address select
 * register, identifier registers, flash programming unlock and data port.
 * Assumes the host drives the link clock, idles clock and data high, and
 * frames each access with a start (data falling while the clock is high).
 * The flash engine sits on core_clk and talks through the flash ports.
 */
`timescale 1ns/100ps

`include "dlra_defs.svh"

// Notes on behaviour
// - An 8-bit read/write address select register, written and read over the link, picks the data register.
// - With select 0x00 a data read returns the part identifier.
// - With select 0x01 a data read returns the revision identifier.
// - With select 0x02 data reads and writes reach the programming control register.
// - With select 0xB4 data reads and writes reach the programming data port.
// - The part identifier is a fixed read-only byte, also seen at debug address 0xFD.
// - The revision identifier is a read-only byte from the silicon revision, also seen at 0xFE.
// - Programming is enabled only after 0x02 and then 0x01 are written to the control register.
// - Once enabled, programming stays enabled until a system reset, which the host issues.
// - The programming data port is an 8-bit register the host can read and write.
// - The data port carries flash commands 0x06 block read, 0x07 block write, 0x08 page erase.
module dlra_link_regs #(
   // arbitrary neutral value, not a real part code
   parameter logic [7:0] PART_ID_CODE = 8'h5A
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic debugLinkClock,
   input wire logic debugLinkDataIn,
   output logic debugLinkDataOut,
   output logic debugLinkDataOe,
   input wire logic [7:0] revisionStrap,
   input wire logic flashDataValid,
   input wire logic [7:0] flashDataIn,
   input wire logic flashDone,
   output logic programEnabled,
   output logic dataPortWrite,
   output logic dataPortRead,
   output logic [7:0] dataPortValue,
   output logic flashCmdValid,
   output dlra_pkg::dlra_flash_cmd_t flashCmd
);
   import dlra_pkg::*;

   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic clockRise, clockFall, clockLevel, dataLevel, dataFall, dataRise;

   // link clock comes from the host and is only sampled here
   dlra_link_sync linkSync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .debugLinkClock(debugLinkClock),
      .debugLinkDataIn(debugLinkDataIn),
      .clockRise(clockRise),
      .clockFall(clockFall),
      .clockLevel(clockLevel),
      .dataLevel(dataLevel),
      .dataFall(dataFall),
      .dataRise(dataRise)
   );

   // ----------------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------------
   dlra_frame_t frame_q, frame_d;
   dlra_instr_t instr_q, instr_d;
   logic [2:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d, commitByte_q, commitByte_d;
   logic dataOut_q, dataOut_d, dataOe_q, dataOe_d, commit_q, commit_d;
   logic commitAddr_q, commitAddr_d, readTaken_q, readTaken_d;

   logic [7:0] addrSel_q, addrSel_d, progCtl_q, progCtl_d, progData_q, progData_d;
   dlra_unlock_t unlock_q, unlock_d;
   logic expectCmd_q, expectCmd_d, portWrite_q, portWrite_d, portRead_q, portRead_d;
   logic cmdValid_q, cmdValid_d, enabled_q, enabled_d;
   dlra_flash_cmd_t cmd_q, cmd_d;

   logic [7:0] revision_identifier_q, revision_identifier_d, readValue;
   logic strapTaken_q, strapTaken_d, startSeen, abortSeen;

   // ----------------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------------
   always_comb begin
      case (addrSel_q)
         `DLRA_SEL_PART_ID, `DLRA_ADDR_PART_ID: readValue = PART_ID_CODE;
         `DLRA_SEL_REV_ID, `DLRA_ADDR_REV_ID: readValue = revision_identifier_q;
         `DLRA_SEL_PROG_CTL: readValue = progCtl_q;
         `DLRA_SEL_PROG_DATA: readValue = progData_q;
         default: readValue = `DLRA_UNMAPPED_READ;
      endcase
   end

   // ----------------------------------------------------------------------
   // frame engine
   // ----------------------------------------------------------------------
   // a start is only honoured while the pin is not ours; our own drive
   // would otherwise look like a host start and tear the frame down
   assign startSeen = dataFall & clockLevel & ~dataOe_q;
   assign abortSeen = dataRise & clockLevel & ~dataOe_q & (frame_q != DLRA_FR_IDLE);

   always_comb begin
      frame_d = frame_q;
      instr_d = instr_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      dataOut_d = dataOut_q;
      dataOe_d = dataOe_q;
      commit_d = 1'b0;
      commitAddr_d = commitAddr_q;
      commitByte_d = commitByte_q;
      readTaken_d = 1'b0;
      if (startSeen) begin
         frame_d = DLRA_FR_INSTR;
         bitCnt_d = 3'h0;
      end else if (abortSeen) begin
         frame_d = DLRA_FR_IDLE;
      end else begin
         case (frame_q)
            DLRA_FR_IDLE: begin
               dataOe_d = 1'b0;
            end
            DLRA_FR_INSTR: begin
               if (clockRise) begin
                  instr_d = dlra_instr_t'({instr_q[0], dataLevel});
                  bitCnt_d = bitCnt_q + 3'h1;
                  if (bitCnt_q == `DLRA_INSTR_LAST_BIT) begin
                     bitCnt_d = 3'h0;
                     if (dataLevel) begin
                        frame_d = DLRA_FR_WRDATA;
                     end else begin
                        frame_d = DLRA_FR_RDWAIT;
                     end
                  end
               end
            end
            DLRA_FR_WRDATA: begin
               if (clockRise) begin
                  shift_d = {shift_q[6:0], dataLevel};
                  bitCnt_d = bitCnt_q + 3'h1;
                  if (bitCnt_q == `DLRA_BYTE_LAST_BIT) begin
                     commit_d = 1'b1;
                     commitAddr_d = (instr_q == DLRA_INS_ADDR_WR);
                     commitByte_d = {shift_q[6:0], dataLevel};
                     frame_d = DLRA_FR_IDLE;
                  end
               end
            end
            DLRA_FR_RDWAIT: begin
               // device takes the line at the first falling edge after the instruction
               if (clockFall) begin
                  shift_d = (instr_q == DLRA_INS_ADDR_RD) ? addrSel_q : readValue;
                  readTaken_d = (instr_q == DLRA_INS_DATA_RD);
                  dataOut_d = (instr_q == DLRA_INS_ADDR_RD) ? addrSel_q[7] : readValue[7];
                  dataOe_d = 1'b1;
                  frame_d = DLRA_FR_RDDATA;
               end
            end
            DLRA_FR_RDDATA: begin
               if (clockRise) begin
                  bitCnt_d = bitCnt_q + 3'h1;
                  if (bitCnt_q == `DLRA_BYTE_LAST_BIT) begin
                     frame_d = DLRA_FR_RDEND;
                  end
               end else if (clockFall) begin
                  shift_d = {shift_q[6:0], 1'b0};
                  dataOut_d = shift_q[6];
               end
            end
            DLRA_FR_RDEND: begin
               if (clockFall) begin
                  dataOe_d = 1'b0;
                  dataOut_d = 1'b1;
                  frame_d = DLRA_FR_IDLE;
               end
            end
            default: begin
               frame_d = DLRA_FR_IDLE;
               dataOe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= DLRA_FR_IDLE;
         instr_q <= DLRA_INS_DATA_RD;
         bitCnt_q <= 3'h0;
         shift_q <= 8'h00;
         dataOut_q <= 1'b1;
         dataOe_q <= 1'b0;
         commit_q <= 1'b0;
         commitAddr_q <= 1'b0;
         commitByte_q <= 8'h00;
         readTaken_q <= 1'b0;
      end else begin
         frame_q <= frame_d;
         instr_q <= instr_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         dataOut_q <= dataOut_d;
         dataOe_q <= dataOe_d;
         commit_q <= commit_d;
         commitAddr_q <= commitAddr_d;
         commitByte_q <= commitByte_d;
         readTaken_q <= readTaken_d;
      end
   end

   // ----------------------------------------------------------------------
   // register file and programming unlock
   // ----------------------------------------------------------------------
   always_comb begin
      addrSel_d = addrSel_q;
      progCtl_d = progCtl_q;
      progData_d = progData_q;
      unlock_d = unlock_q;
      expectCmd_d = expectCmd_q;
      portWrite_d = 1'b0;
      portRead_d = 1'b0;
      cmdValid_d = 1'b0;
      cmd_d = cmd_q;
      strapTaken_d = 1'b1;
      // the strap is caught once, on the first clock after reset release
      revision_identifier_d = strapTaken_q ? revision_identifier_q : revisionStrap;
      // a finished flash job re-arms command decoding
      if (flashDone && unlock_q == DLRA_UL_ENABLED) begin
         expectCmd_d = 1'b1;
      end
      // flash engine results land in the data port for the host to read
      if (flashDataValid) begin
         progData_d = flashDataIn;
      end
      if (readTaken_q && addrSel_q == `DLRA_SEL_PROG_DATA) begin
         portRead_d = 1'b1;
      end
      if (commit_q) begin
         if (commitAddr_q) begin
            addrSel_d = commitByte_q;
         end else begin
            case (addrSel_q)
               `DLRA_SEL_PROG_CTL: begin
                  progCtl_d = commitByte_q;
                  case (unlock_q)
                     DLRA_UL_ENABLED: unlock_d = DLRA_UL_ENABLED;
                     default: begin
                        if (unlock_q == DLRA_UL_FIRST && commitByte_q == `DLRA_UNLOCK_SECOND) begin
                           unlock_d = DLRA_UL_ENABLED;
                           expectCmd_d = 1'b1;
                        end else if (commitByte_q == `DLRA_UNLOCK_FIRST) begin
                           unlock_d = DLRA_UL_FIRST;
                        end else begin
                           unlock_d = DLRA_UL_LOCKED;
                        end
                     end
                  endcase
               end
               `DLRA_SEL_PROG_DATA: begin
                  // host write beats a same-cycle engine load
                  progData_d = commitByte_q;
                  portWrite_d = 1'b1;
                  if (expectCmd_q && unlock_q == DLRA_UL_ENABLED) begin
                     expectCmd_d = 1'b0;
                     cmdValid_d = 1'b1;
                     case (commitByte_q)
                        `DLRA_CMD_BLOCK_READ: cmd_d = DLRA_FC_BLOCK_READ;
                        `DLRA_CMD_BLOCK_WRITE: cmd_d = DLRA_FC_BLOCK_WRITE;
                        `DLRA_CMD_PAGE_ERASE: cmd_d = DLRA_FC_PAGE_ERASE;
                        default: cmd_d = DLRA_FC_NONE;
                     endcase
                  end
               end
               // identifier and unmapped selections drop the write
               default: progCtl_d = progCtl_q;
            endcase
         end
      end
      enabled_d = (unlock_d == DLRA_UL_ENABLED);
   end

   // only a system reset leaves programming mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addrSel_q <= `DLRA_ADDR_SEL_RST;
         progCtl_q <= `DLRA_PROG_CTL_RST;
         progData_q <= `DLRA_PROG_DATA_RST;
         unlock_q <= DLRA_UL_LOCKED;
         expectCmd_q <= 1'b0;
         portWrite_q <= 1'b0;
         portRead_q <= 1'b0;
         cmdValid_q <= 1'b0;
         cmd_q <= DLRA_FC_NONE;
         enabled_q <= 1'b0;
         revision_identifier_q <= 8'h00;
         strapTaken_q <= 1'b0;
      end else begin
         addrSel_q <= addrSel_d;
         progCtl_q <= progCtl_d;
         progData_q <= progData_d;
         unlock_q <= unlock_d;
         expectCmd_q <= expectCmd_d;
         portWrite_q <= portWrite_d;
         portRead_q <= portRead_d;
         cmdValid_q <= cmdValid_d;
         cmd_q <= cmd_d;
         enabled_q <= enabled_d;
         revision_identifier_q <= revision_identifier_d;
         strapTaken_q <= strapTaken_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign debugLinkDataOut = dataOut_q;
   assign debugLinkDataOe = dataOe_q;
   assign programEnabled = enabled_q;
   assign dataPortWrite = portWrite_q;
   assign dataPortRead = portRead_q;
   assign dataPortValue = progData_q;
   assign flashCmdValid = cmdValid_q;
   assign flashCmd = cmd_q;

endmodule // dlra_link_regs

// >>> rtl/dlra_defs.svh
/*
 * Constants of the debug link register block: register select codes,
 * unlock codes, flash command codes and reset values.
 * Assumes inclusion by bare name from files that need them.
 */
`ifndef DLRA_DEFS_SVH
`define DLRA_DEFS_SVH

// ----------------------------------------------------------------------
// data register selection by address select value
// ----------------------------------------------------------------------
`define DLRA_SEL_PART_ID 8'h00
`define DLRA_SEL_REV_ID 8'h01
`define DLRA_SEL_PROG_CTL 8'h02
`define DLRA_SEL_PROG_DATA 8'hB4
`define DLRA_ADDR_PART_ID 8'hFD
`define DLRA_ADDR_REV_ID 8'hFE

// ----------------------------------------------------------------------
// reset values and the value read at unmapped selections
// ----------------------------------------------------------------------
`define DLRA_ADDR_SEL_RST 8'h00
`define DLRA_PROG_CTL_RST 8'h00
`define DLRA_PROG_DATA_RST 8'h00
`define DLRA_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------
// unlock sequence and flash commands
// ----------------------------------------------------------------------
`define DLRA_UNLOCK_FIRST 8'h02
`define DLRA_UNLOCK_SECOND 8'h01
`define DLRA_CMD_BLOCK_READ 8'h06
`define DLRA_CMD_BLOCK_WRITE 8'h07
`define DLRA_CMD_PAGE_ERASE 8'h08

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define DLRA_BYTE_LAST_BIT 3'h7
`define DLRA_INSTR_LAST_BIT 3'h1

`endif

// >>> rtl/dlra_pkg.sv
/*
 * Types of the debug link register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dlra_pkg;

   // instruction carried by the first two bits of a frame
   typedef enum logic [1:0] {
      DLRA_INS_DATA_RD = 2'h0,
      DLRA_INS_DATA_WR = 2'h1,
      DLRA_INS_ADDR_RD = 2'h2,
      DLRA_INS_ADDR_WR = 2'h3
   } dlra_instr_t;

   typedef enum {
      DLRA_FR_IDLE,
      DLRA_FR_INSTR,
      DLRA_FR_WRDATA,
      DLRA_FR_RDWAIT,
      DLRA_FR_RDDATA,
      DLRA_FR_RDEND
   } dlra_frame_t;

   typedef enum {
      DLRA_UL_LOCKED,
      DLRA_UL_FIRST,
      DLRA_UL_ENABLED
   } dlra_unlock_t;

   typedef enum logic [1:0] {
      DLRA_FC_BLOCK_READ = 2'h0,
      DLRA_FC_BLOCK_WRITE = 2'h1,
      DLRA_FC_PAGE_ERASE = 2'h2,
      DLRA_FC_NONE = 2'h3
   } dlra_flash_cmd_t;

endpackage

// >>> rtl/dlra_link_sync.sv
/*
 * Synchroniser and edge finder for the debug link clock and data pins.
 * Assumes both pins are asynchronous to core_clk and that each link
 * clock phase lasts at least three core_clk periods.
 */
`timescale 1ns/100ps

module dlra_link_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic debugLinkClock,
   input wire logic debugLinkDataIn,
   output logic clockRise,
   output logic clockFall,
   output logic clockLevel,
   output logic dataLevel,
   output logic dataFall,
   output logic dataRise
);

   logic [1:0] clkMeta_q, clkMeta_d;
   logic [1:0] datMeta_q, datMeta_d;
   logic clkPrev_q, clkPrev_d;
   logic datPrev_q, datPrev_d;

   // only stage 1 reads stage 0; edges compare stage 1 with its delayed copy
   always_comb begin
      clkMeta_d = {clkMeta_q[0], debugLinkClock};
      datMeta_d = {datMeta_q[0], debugLinkDataIn};
      clkPrev_d = clkMeta_q[1];
      datPrev_d = datMeta_q[1];
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkMeta_q <= 2'h3;
         datMeta_q <= 2'h3;
         clkPrev_q <= 1'b1;
         datPrev_q <= 1'b1;
      end else begin
         clkMeta_q <= clkMeta_d;
         datMeta_q <= datMeta_d;
         clkPrev_q <= clkPrev_d;
         datPrev_q <= datPrev_d;
      end
   end

   assign clockLevel = clkMeta_q[1];
   assign dataLevel = datMeta_q[1];
   assign clockRise = clkMeta_q[1] & ~clkPrev_q;
   assign clockFall = ~clkMeta_q[1] & clkPrev_q;
   assign dataFall = ~datMeta_q[1] & datPrev_q;
   assign dataRise = datMeta_q[1] & ~datPrev_q;

endmodule // dlra_link_sync

// >>> dv/dlra_checker.sv
/* Port checker of the debug link register block.
   Assumes it is bound onto dlra_link_regs and sees only its ports. */
`timescale 1ns/100ps
`include "dlra_defs.svh"
module dlra_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic debugLinkClock,
   input wire logic debugLinkDataIn,
   input wire logic debugLinkDataOut,
   input wire logic debugLinkDataOe,
   input wire logic [7:0] revisionStrap,
   input wire logic flashDataValid,
   input wire logic [7:0] flashDataIn,
   input wire logic flashDone,
   input wire logic programEnabled,
   input wire logic dataPortWrite,
   input wire logic dataPortRead,
   input wire logic [7:0] dataPortValue,
   input wire logic flashCmdValid,
   input wire dlra_pkg::dlra_flash_cmd_t flashCmd
);
   import dlra_pkg::*;
   // ----
   // command expected from the data port byte
   // ----
   dlra_flash_cmd_t expCmd;
   always_comb begin
      case (dataPortValue)
         `DLRA_CMD_BLOCK_READ: expCmd = DLRA_FC_BLOCK_READ;
         `DLRA_CMD_BLOCK_WRITE: expCmd = DLRA_FC_BLOCK_WRITE;
         `DLRA_CMD_PAGE_ERASE: expCmd = DLRA_FC_PAGE_ERASE;
         default: expCmd = DLRA_FC_NONE;
      endcase
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_load; flashDataValid ##1 !dataPortWrite; endsequence
   sequence s_quiet; !flashDataValid ##1 !dataPortWrite; endsequence
   property p_enable_sticky; programEnabled |=> programEnabled; endproperty
   a_enable_sticky: assert property (p_enable_sticky) else $error("program enable dropped");
   property p_enable_rise; $rose(programEnabled) |-> !debugLinkDataOe; endproperty
   a_enable_rise: assert property (p_enable_rise) else $error("enable rose during a read");
   property p_cmd_decode; flashCmdValid |-> flashCmd == expCmd; endproperty
   a_cmd_decode: assert property (p_cmd_decode) else $error("flash command decoded wrongly");
   property p_cmd_cause; flashCmdValid |-> programEnabled && dataPortWrite; endproperty
   a_cmd_cause: assert property (p_cmd_cause) else $error("command without enabled write");
   property p_load; s_load |-> dataPortValue == $past(flashDataIn); endproperty
   a_load: assert property (p_load) else $error("data port missed flash load");
   property p_hold; s_quiet |-> $stable(dataPortValue); endproperty
   a_hold: assert property (p_hold) else $error("data port changed by itself");
   property p_wr_pulse; dataPortWrite |=> !dataPortWrite && !debugLinkDataOe; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
   property p_rd_bit; dataPortRead |-> debugLinkDataOe && debugLinkDataOut == dataPortValue[7]; endproperty
   a_rd_bit: assert property (p_rd_bit) else $error("data port read not driving top bit");
   property p_idle_high; !debugLinkDataOe |-> debugLinkDataOut; endproperty
   a_idle_high: assert property (p_idle_high) else $error("data out low while released");
   property p_drive_low; $rose(debugLinkDataOe) |-> !debugLinkClock; endproperty
   a_drive_low: assert property (p_drive_low) else $error("drive began with link clock high");
endmodule // dlra_checker
bind dlra_link_regs dlra_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .debugLinkClock(debugLinkClock),
   .debugLinkDataIn(debugLinkDataIn), .debugLinkDataOut(debugLinkDataOut), .debugLinkDataOe(debugLinkDataOe),
   .revisionStrap(revisionStrap), .flashDataValid(flashDataValid), .flashDataIn(flashDataIn),
   .flashDone(flashDone), .programEnabled(programEnabled), .dataPortWrite(dataPortWrite),
   .dataPortRead(dataPortRead), .dataPortValue(dataPortValue), .flashCmdValid(flashCmdValid),
   .flashCmd(flashCmd));

// >>> dv/dlra_host_model.sv
/* Programming host adapter: drives the link clock and shares the data line.
   Assumes a pull-up on the data line and an 800 ns link clock period. */
`timescale 1ns/100ps
module dlra_host_model (
   input wire logic devOut,
   input wire logic devOe,
   output logic linkClock,
   output logic linkData
);
   logic hostOe;
   logic hostBit;
   // released by both sides the line floats up to the pull-up level
   assign linkData = devOe ? devOut : (hostOe ? hostBit : 1'b1);
   initial begin
      linkClock = 1'b1;
      hostOe = 1'b1;
      hostBit = 1'b1;
   end
   // ----
   // link cycles
   // ----
   // low phase longer than high so the device's late drive settles before sampling
   task automatic bitCycle(input logic drive, input logic b, output logic s);
      linkClock = 1'b0;
      hostOe = drive;
      hostBit = b;
      #450;
      s = linkData;
      linkClock = 1'b1;
      #350;
   endtask
   task automatic frame(input logic [1:0] ins, input logic [7:0] wr, output logic [7:0] rd);
      logic s;
      hostBit = 1'b0;
      #400;
      for (int i = 1; i >= 0; i--) bitCycle(1'b1, ins[i], s);
      for (int i = 7; i >= 0; i--) begin
         bitCycle(ins[0], wr[i], s);
         rd[i] = s;
      end
      // a read ends on one more falling edge, where the device lets go
      if (!ins[0]) bitCycle(1'b0, 1'b1, s);
      #400;
      hostOe = 1'b1;
      hostBit = 1'b1;
      #800;
   endtask
endmodule // dlra_host_model

// >>> dv/tb_top.sv
/* Bench top: clock, reset, flash-side stimulus and scenarios.
   Assumes the host model drives the link and the checker is bound in. */
`timescale 1ns/100ps
`include "dlra_defs.svh"
module tb_top;
   import dlra_pkg::*;
   localparam logic [7:0] PART = 8'hA5; // arbitrary value, not a real part code
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   logic core_clk, rst_n, linkClock, linkData, devOut, devOe;
   logic [7:0] revisionStrap, flashDataIn, dataPortValue, rd;
   logic flashDataValid, flashDone, programEnabled, dataPortWrite, dataPortRead, flashCmdValid;
   dlra_flash_cmd_t flashCmd, lastCmd;
   int nMismatch = 0, testsRun = 0, nWrite = 0, nRead = 0, nCmd = 0;
   dlra_link_regs #(.PART_ID_CODE(PART)) dut (.core_clk(core_clk), .rst_n(rst_n), .debugLinkClock(linkClock),
      .debugLinkDataIn(linkData), .debugLinkDataOut(devOut), .debugLinkDataOe(devOe),
      .revisionStrap(revisionStrap), .flashDataValid(flashDataValid), .flashDataIn(flashDataIn),
      .flashDone(flashDone), .programEnabled(programEnabled), .dataPortWrite(dataPortWrite),
      .dataPortRead(dataPortRead), .dataPortValue(dataPortValue), .flashCmdValid(flashCmdValid),
      .flashCmd(flashCmd));
   dlra_host_model host (.devOut(devOut), .devOe(devOe), .linkClock(linkClock), .linkData(linkData));
   always @(posedge core_clk) begin
      if (dataPortWrite === 1'b1) nWrite++;
      if (dataPortRead === 1'b1) nRead++;
      if (flashCmdValid === 1'b1) begin
         nCmd++;
         lastCmd = flashCmd;
      end
   end
   // ----
   // shared tasks
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic doReset(input logic [7:0] strap);
      @(posedge core_clk);
      #10;
      rst_n = 1'b0;
      revisionStrap = strap;
      repeat (20) @(posedge core_clk);
      #10;
      rst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #10;
   endtask
   task automatic wrAddr(input logic [7:0] v);
      host.frame(DLRA_INS_ADDR_WR, v, rd);
   endtask
   task automatic wrData(input logic [7:0] v);
      host.frame(DLRA_INS_DATA_WR, v, rd);
   endtask
   task automatic rdData;
      host.frame(DLRA_INS_DATA_RD, 8'hFF, rd);
   endtask
   task automatic flashPulse(input logic load, input logic [7:0] v);
      @(posedge core_clk);
      #10;
      flashDataValid = load;
      flashDone = !load;
      flashDataIn = v;
      @(posedge core_clk);
      #10;
      flashDataValid = 1'b0;
      flashDone = 1'b0;
   endtask
   // ----
   // scenarios
   // ----
   task automatic tReset;
      host.frame(DLRA_INS_ADDR_RD, 8'hFF, rd);
      check(rd, `DLRA_ADDR_SEL_RST);
      check({7'h0, programEnabled}, 8'h00);
      wrAddr(`DLRA_SEL_PROG_CTL);
      rdData();
      check(rd, `DLRA_PROG_CTL_RST);
   endtask
   task automatic tIds;
      logic [7:0] sel [4];
      logic [7:0] exp [4];
      sel = '{`DLRA_SEL_PART_ID, `DLRA_SEL_REV_ID, `DLRA_ADDR_PART_ID, `DLRA_ADDR_REV_ID};
      exp = '{PART, REV, PART, REV};
      foreach (sel[i]) begin
         wrAddr(sel[i]);
         host.frame(DLRA_INS_ADDR_RD, 8'hFF, rd);
         check(rd, sel[i]);
         wrData(~exp[i]);
         rdData();
         check(rd, exp[i]);
      end
      wrAddr(8'h33);
      rdData();
      check(rd, `DLRA_UNMAPPED_READ);
   endtask
   task automatic tPort;
      int w0, r0, c0;
      w0 = nWrite;
      c0 = nCmd;
      wrAddr(`DLRA_SEL_PROG_DATA);
      wrData(8'h5C);
      check(dataPortValue, 8'h5C);
      check(8'(nWrite - w0), 8'h01);
      check(8'(nCmd - c0), 8'h00);
      r0 = nRead;
      rdData();
      check(rd, 8'h5C);
      check(8'(nRead - r0), 8'h01);
      flashPulse(1'b1, 8'hC3);
      rdData();
      check(rd, 8'hC3);
   endtask
   task automatic tUnlock;
      logic [7:0] bad [4];
      bad = '{8'h01, 8'h02, 8'h07, 8'h01};
      wrAddr(`DLRA_SEL_PROG_CTL);
      foreach (bad[i]) wrData(bad[i]);
      check({7'h0, programEnabled}, 8'h00);
      rdData();
      check(rd, 8'h01);
      wrData(`DLRA_UNLOCK_FIRST);
      wrData(`DLRA_UNLOCK_FIRST);
      check({7'h0, programEnabled}, 8'h00);
      wrData(`DLRA_UNLOCK_SECOND);
      check({7'h0, programEnabled}, 8'h01);
   endtask
   task automatic tCmds;
      logic [7:0] code [4];
      dlra_flash_cmd_t exp [4];
      int c0;
      code = '{`DLRA_CMD_BLOCK_READ, `DLRA_CMD_BLOCK_WRITE, `DLRA_CMD_PAGE_ERASE, 8'h55};
      exp = '{DLRA_FC_BLOCK_READ, DLRA_FC_BLOCK_WRITE, DLRA_FC_PAGE_ERASE, DLRA_FC_NONE};
      wrAddr(`DLRA_SEL_PROG_DATA);
      foreach (code[i]) begin
         c0 = nCmd;
         wrData(code[i]);
         check({6'h0, lastCmd}, {6'h0, exp[i]});
         // a second byte before the flash engine is done is data, not a command
         wrData(8'h11);
         check(8'(nCmd - c0), 8'h01);
         flashPulse(1'b0, 8'h00);
      end
   endtask
   task automatic tSticky;
      wrAddr(`DLRA_SEL_PROG_CTL);
      wrData(8'h00);
      check({7'h0, programEnabled}, 8'h01);
      doReset(8'h6E);
      check({7'h0, programEnabled}, 8'h00);
      wrAddr(`DLRA_SEL_REV_ID);
      rdData();
      check(rd, 8'h6E);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      rst_n = 1'b0;
      revisionStrap = REV;
      flashDataValid = 1'b0;
      flashDone = 1'b0;
      flashDataIn = 8'h00;
      doReset(REV);
      tReset();
      tIds();
      tPort();
      tUnlock();
      tCmds();
      tSticky();
      summarize();
   end
   // about six times the expected run length
   initial begin
      #3_000_000;
      nMismatch++;
      summarize();
   end
endmodule // tb_top
